// file: core/sdm_sweep_drive.sv
/*
 * Sweep drive and marker control: blanking level, marker output, ramp
 * start/stop gating, range switches, ramp reset and integrity flag,
 * relay drive timeout.
 * Assumes all inputs are synchronous to mclk except sweep_limit_pulse,
 * which is synchronised here.
 */
// Notes on behaviour
// - Single sweep: blank goes low at sweep start, high at end, stays high.
// - Continuous sweep: blank is low on the way up, high on the way down.
// - Marker pulses only during linear upward sweeps.
// - Marker forced high by its preset and low by its clear; never both.
// - With strobes idle the marker loads its next value on a limit edge.
// - Ramp start/stop forced high by its preset and low by its clear.
// - With strobes idle the ramp element loads its next value on a limit edge.
// - Only the selected range switch is on while the ramp element is high.
// - After a single sweep the ramp stays at full scale until reset.
// - Continuous sweep pulses the ramp reset at each downward start.
// - Digital detector reset below 100 Hz, analog comparator at or above.
// - Digital reset sets the integrity flag; analog reset blocks it.
// - Relay drive turns off once the relay has switched.
`timescale 1ns/1ps
module sdm_sweep_drive #(
   parameter int unsigned RELAY_CYC = sdm_pkg::RELAY_ON_CYC,
   parameter int unsigned RELAYS    = 8
) (
   // Clock and reset
   input  wire logic              mclk,
   input  wire logic              rstn,
   // Sweep control
   input  wire sdm_pkg::sdm_ctrl_t ctrl,
   input  wire logic              sweep_limit_pulse,
   input  wire logic              marker_preset_n,
   input  wire logic              marker_clear_n,
   input  wire logic              marker_next_value,
   input  wire logic              hramp_preset_n,
   input  wire logic              hramp_clear_n,
   input  wire logic              hramp_next_value,
   input  wire logic              range_short,
   input  wire logic              range_long,
   // Ramp reset sources
   input  wire logic [31:0]       out_freq_hz,
   input  wire logic              phase_det_reset,
   input  wire logic              analog_ramp_reset_pos,
   input  wire logic              analog_ramp_reset_neg,
   input  wire logic              flag_clear,
   // Relay requests
   input  wire logic [RELAYS-1:0] relay_request,
   // Outputs
   output logic                   sweep_blank,
   output logic                   marker_out,
   output logic                   hramp_run,
   output logic                   switch_short,
   output logic                   switch_long,
   output logic                   hramp_reset,
   output logic                   use_digital_reset,
   output logic                   function_integrity_bit,
   output logic [RELAYS-1:0]      relay_drive
);

   localparam int unsigned PW  = $clog2(sdm_pkg::RESET_PULSE_CYC + 1);
   localparam int unsigned RW  = $clog2(RELAY_CYC + 1);

   logic                 lim_s1, lim_s2, lim_s3;
   logic                 next_lim_s1, next_lim_s2, next_lim_s3;
   logic                 limit_edge;
   sdm_pkg::sdm_phase_t  phase, next_phase;
   logic                 blank, next_blank;
   logic                 mark_q, ramp_q;
   logic [PW-1:0]        rst_cnt, next_rst_cnt;
   logic                 flag, next_flag;
   logic                 dig, next_dig;
   logic                 down_d, next_down_d;

   always_comb begin
      next_lim_s1 = sweep_limit_pulse;
      next_lim_s2 = lim_s1;
      next_lim_s3 = lim_s2;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         lim_s1 <= 1'b0;
         lim_s2 <= 1'b0;
         lim_s3 <= 1'b0;
      end else begin
         lim_s1 <= next_lim_s1;
         lim_s2 <= next_lim_s2;
         lim_s3 <= next_lim_s3;
      end
   end

   assign limit_edge = lim_s2 & ~lim_s3;

   sdm_flop #(.RST_VAL(sdm_pkg::MARKER_RST)) u_marker (
      .mclk       (mclk),
      .rstn       (rstn),
      .preset_n   (marker_preset_n),
      .clear_n    (marker_clear_n),
      .load       (limit_edge),
      .next_value (marker_next_value),
      .q          (mark_q)
   );

   // ramp start/stop element; preset held by controller
   sdm_flop #(.RST_VAL(sdm_pkg::HRAMP_RST)) u_hramp (
      .mclk       (mclk),
      .rstn       (rstn),
      .preset_n   (hramp_preset_n),
      .clear_n    (hramp_clear_n),
      .load       (limit_edge),
      .next_value (hramp_next_value),
      .q          (ramp_q)
   );

   // Sweep phase and blanking
   always_comb begin
      next_phase = phase;
      next_blank = blank;
      case (phase)
         sdm_pkg::SDM_IDLE, sdm_pkg::SDM_DONE: begin
            if (ctrl.sweep_start) begin
               next_phase = sdm_pkg::SDM_UP;
               next_blank = 1'b0;
            end
         end
         sdm_pkg::SDM_UP: begin
            if (ctrl.single_mode && ctrl.sweep_end) begin
               next_phase = sdm_pkg::SDM_DONE;
               next_blank = 1'b1;
            end else if (!ctrl.single_mode && ctrl.sweep_down) begin
               next_phase = sdm_pkg::SDM_DOWN;
               next_blank = 1'b1;
            end
         end
         sdm_pkg::SDM_DOWN: begin
            if (ctrl.single_mode) begin
               next_phase = sdm_pkg::SDM_DONE;
               next_blank = 1'b1;
            end else if (!ctrl.sweep_down) begin
               next_phase = sdm_pkg::SDM_UP;
               next_blank = 1'b0;
            end
         end
         default: begin
            next_phase = sdm_pkg::SDM_IDLE;
            next_blank = sdm_pkg::BLANK_RST;
         end
      endcase
   end

   // Ramp reset pulse: continuous down start, or new single sweep start
   always_comb begin
      next_down_d  = ctrl.sweep_down;
      next_rst_cnt = rst_cnt;
      if (rst_cnt != '0) begin
         next_rst_cnt = rst_cnt - PW'(1);
      end
      // pulse at start of each downward sweep
      if (!ctrl.single_mode && ctrl.sweep_down && !down_d) begin
         next_rst_cnt = PW'(sdm_pkg::RESET_PULSE_CYC);
      end
      // full scale held until reset before next sweep
      if (ctrl.single_mode && ctrl.sweep_start) begin
         next_rst_cnt = PW'(sdm_pkg::RESET_PULSE_CYC);
      end
   end

   // Reset method and integrity flag
   always_comb begin
      next_dig  = (out_freq_hz < sdm_pkg::FREQ_SPLIT_HZ);
      next_flag = flag;
      if (flag_clear) begin
         next_flag = 1'b0;
      end
      // analog reset blocks the set; digital set wins over clear
      if (dig && phase_det_reset && !(analog_ramp_reset_pos || analog_ramp_reset_neg)) begin
         next_flag = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         phase   <= sdm_pkg::SDM_IDLE;
         blank   <= sdm_pkg::BLANK_RST;
         rst_cnt <= '0;
         down_d  <= 1'b0;
         flag    <= sdm_pkg::INTEG_RST;
         dig     <= 1'b0;
      end else begin
         phase   <= next_phase;
         blank   <= next_blank;
         rst_cnt <= next_rst_cnt;
         down_d  <= next_down_d;
         flag    <= next_flag;
         dig     <= next_dig;
      end
   end

   // Relay drivers: each timed out after the switching interval
   genvar gi;
   generate
      for (gi = 0; gi < RELAYS; gi++) begin : g_relay
         logic [RW-1:0] cnt, next_cnt;
         always_comb begin
            next_cnt = cnt;
            if (relay_request[gi]) begin
               next_cnt = RW'(RELAY_CYC);
            end else if (cnt != '0) begin
               next_cnt = cnt - RW'(1);
            end
         end
         always_ff @(posedge mclk or negedge rstn) begin
            if (!rstn) begin
               cnt <= '0;
            end else begin
               cnt <= next_cnt;
            end
         end
         assign relay_drive[gi] = (cnt != '0);
      end
   endgenerate

   // Outputs
   assign sweep_blank            = blank;
   // marker only in linear up sweep
   assign marker_out             = mark_q & (phase == sdm_pkg::SDM_UP) & ~ctrl.log_sweep;
   assign hramp_run              = ramp_q;
   // only the selected switch while running
   assign switch_short           = ramp_q & range_short & ~range_long;
   assign switch_long            = ramp_q & range_long & ~range_short;
   assign hramp_reset            = (rst_cnt != '0);
   assign use_digital_reset      = dig;
   assign function_integrity_bit = flag;

   chk_marker_linear_up: assert property (@(posedge mclk) disable iff (!rstn)
      marker_out |-> (phase == sdm_pkg::SDM_UP) && !ctrl.log_sweep)
      else $error("marker outside linear up sweep");

   chk_blank_start: assert property (@(posedge mclk) disable iff (!rstn)
      (phase == sdm_pkg::SDM_DONE) && ctrl.sweep_start |=> !sweep_blank)
      else $error("blank not low at sweep start");

   chk_blank_cont: assert property (@(posedge mclk) disable iff (!rstn)
      (phase == sdm_pkg::SDM_DOWN) |-> sweep_blank)
      else $error("blank low during down sweep");

   chk_marker_preset: assert property (@(posedge mclk) disable iff (!rstn)
      !marker_preset_n |-> mark_q)
      else $error("marker preset ignored");

   chk_marker_load: assert property (@(posedge mclk) disable iff (!rstn)
      marker_preset_n && marker_clear_n && limit_edge ##1 marker_preset_n && marker_clear_n
      |-> mark_q == $past(marker_next_value))
      else $error("marker load wrong");

   chk_hramp_clear: assert property (@(posedge mclk) disable iff (!rstn)
      hramp_preset_n && !hramp_clear_n |-> !hramp_run)
      else $error("ramp clear ignored");

   chk_hramp_hold: assert property (@(posedge mclk) disable iff (!rstn)
      hramp_preset_n && hramp_clear_n && !limit_edge ##1 hramp_preset_n && hramp_clear_n
      |-> $stable(hramp_run))
      else $error("ramp element changed without edge");

   chk_range_switch: assert property (@(posedge mclk) disable iff (!rstn)
      (switch_short || switch_long) |-> hramp_run && !(switch_short && switch_long)
         && (switch_short == range_short) && (switch_long == range_long))
      else $error("wrong range switch");

   chk_reset_method: assert property (@(posedge mclk) disable iff (!rstn)
      $past(rstn) |-> use_digital_reset == $past(out_freq_hz < sdm_pkg::FREQ_SPLIT_HZ))
      else $error("wrong ramp reset method");

   chk_down_reset: assert property (@(posedge mclk) disable iff (!rstn)
      !ctrl.single_mode && ctrl.sweep_down && !down_d |=> hramp_reset [*3])
      else $error("no ramp reset at down start");

   chk_flag_block: assert property (@(posedge mclk) disable iff (!rstn)
      !flag && (analog_ramp_reset_pos || analog_ramp_reset_neg) |=> !function_integrity_bit)
      else $error("analog reset failed to block flag");

   chk_edge_single: assert property (@(posedge mclk) disable iff (!rstn)
      limit_edge |=> !limit_edge)
      else $error("limit edge longer than one cycle");

endmodule

// file: core/sdm_pkg.sv
/*
 * Package for the sweep drive and marker control block: shared types,
 * reset values and the phase-detector frequency threshold.
 * Assumes a single 50 MHz system clock and an active-low async reset.
 */
package sdm_pkg;

   // Sweep direction and mode as seen by the block
   typedef enum logic [1:0] {
      SDM_IDLE,
      SDM_UP,
      SDM_DOWN,
      SDM_DONE
   } sdm_phase_t;

   // Control inputs from the instrument controller
   typedef struct packed {
      logic single_mode;   // High: single sweep, low: continuous
      logic log_sweep;     // High: logarithmic sweep
      logic sweep_start;   // One-cycle pulse: sweep begins
      logic sweep_end;     // One-cycle pulse: sweep (single) ends
      logic sweep_down;    // Level: continuous sweep running down
   } sdm_ctrl_t;

   // Output frequency threshold for the ramp reset method, in Hz
   localparam int unsigned FREQ_SPLIT_HZ = 100;
   localparam int unsigned FREQ_W        = 32;

   // Clock and ramp reset pulse width
   localparam int unsigned CLK_PERIOD_NS  = 20;
   localparam int unsigned RESET_PULSE_NS = 1000;
   localparam int unsigned RESET_PULSE_CYC =
      (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Relay drive on-time after a switch request
   localparam int unsigned RELAY_ON_US  = 10000;
   localparam int unsigned RELAY_ON_CYC = RELAY_ON_US * 1000 / CLK_PERIOD_NS;

   // Values after reset
   localparam logic BLANK_RST  = 1'b1;
   localparam logic MARKER_RST = 1'b0;
   localparam logic HRAMP_RST  = 1'b0;
   localparam logic INTEG_RST  = 1'b0;

endpackage

// file: core/sdm_flop.sv
/*
 * Start/stop storage element with asynchronous preset and clear strobes,
 * loaded on a single-cycle sweep-limit event.
 * Assumes the strobes are active low and the event is already in mclk.
 */
`timescale 1ns/1ps
module sdm_flop #(
   parameter logic RST_VAL = 1'b0
) (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic rstn,
   // Strobes and load
   input  wire logic preset_n,
   input  wire logic clear_n,
   input  wire logic load,
   input  wire logic next_value,
   // State
   output logic      q
);

   logic state;
   logic next_state;

   // load only with both strobes idle
   // Otherwise keep what the output shows, so a forced level sticks after
   // the strobe is released; a strobe shorter than one clock is not kept
   always_comb begin
      next_state = q;
      if (load && preset_n && clear_n) begin
         next_state = next_value;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state <= RST_VAL;
      end else begin
         state <= next_state;
      end
   end

   // Strobes override asynchronously; preset wins when both are low
   always_comb begin
      if (!preset_n) begin
         q = 1'b1;
      end else if (!clear_n) begin
         q = 1'b0;
      end else begin
         q = state;
      end
   end

endmodule

// file: test/sdm_ctrl_model.sv
/*
 * Behavioural controller at the far side of the sweep drive block.
 * Assumes the bench calls its tasks from one process, after a clock edge.
 */
`timescale 1ns/1ps
module sdm_ctrl_model #(
   parameter int GAP_CYC = 4
) (
   // Clock
   input  wire logic mclk,
   // Limit path and strobes
   output logic      sweep_limit_pulse,
   output logic      marker_preset_n,
   output logic      marker_clear_n,
   output logic      marker_next_value,
   output logic      hramp_preset_n,
   output logic      hramp_clear_n,
   output logic      hramp_next_value,
   // Range selects
   output logic      range_short,
   output logic      range_long
);
   // Idle levels: strobes released, no range chosen yet
   initial begin
      sweep_limit_pulse = 1'h0;
      marker_preset_n   = 1'h1;
      marker_clear_n    = 1'h1;
      marker_next_value = 1'h0;
      hramp_preset_n    = 1'h1;
      hramp_clear_n     = 1'h1;
      hramp_next_value  = 1'h0;
      range_short       = 1'h0;
      range_long        = 1'h0;
   end

   // pairs never both low; preset kept, clear dropped
   task automatic strobe(input logic mp, input logic mc, input logic hp, input logic hc);
      @(posedge mclk);
      marker_preset_n <= mp;
      marker_clear_n  <= mc | ~mp;
      hramp_preset_n  <= hp;
      hramp_clear_n   <= hc | ~hp;
   endtask

   // wide limit pulse, then a gap (scaled down from 400 us)
   task automatic limit(input logic mv, input logic hv);
      @(posedge mclk);
      marker_next_value <= mv;
      hramp_next_value  <= hv;
      sweep_limit_pulse <= 1'h1;
      repeat (3) @(posedge mclk);
      sweep_limit_pulse <= 1'h0;
      repeat (GAP_CYC) @(posedge mclk);
   endtask

   // range from sweep time in ms: short below 1 s, long from 1 s
   task automatic rng(input int ms);
      @(posedge mclk);
      range_short <= (ms < 1000);
      range_long  <= (ms >= 1000);
   endtask
endmodule

// file: test/sdm_sweep_drive_tb_top.sv
/*
 * Self-checking bench for the sweep drive and marker control block.
 * Assumes the design package and the controller model are compiled first.
 */
`timescale 1ns/1ps
module sdm_sweep_drive_tb_top;
   localparam int RCYC = 8;
   logic               mclk, rstn, phase_det_reset, flag_clear;
   logic               analog_ramp_reset_pos, analog_ramp_reset_neg;
   sdm_pkg::sdm_ctrl_t ctrl;
   logic [31:0]        out_freq_hz;
   logic [7:0]         relay_request, relay_drive;
   logic               sweep_limit_pulse, marker_preset_n, marker_clear_n, marker_next_value;
   logic               hramp_preset_n, hramp_clear_n, hramp_next_value, range_short, range_long;
   logic               sweep_blank, marker_out, hramp_run, switch_short, switch_long;
   logic               hramp_reset, use_digital_reset, function_integrity_bit;
   int                 fails, checks;

   sdm_sweep_drive #(.RELAY_CYC(RCYC)) dut (
      .mclk, .rstn, .ctrl, .sweep_limit_pulse, .marker_preset_n, .marker_clear_n,
      .marker_next_value, .hramp_preset_n, .hramp_clear_n, .hramp_next_value,
      .range_short, .range_long, .out_freq_hz, .phase_det_reset, .analog_ramp_reset_pos,
      .analog_ramp_reset_neg, .flag_clear, .relay_request, .sweep_blank, .marker_out,
      .hramp_run, .switch_short, .switch_long, .hramp_reset, .use_digital_reset,
      .function_integrity_bit, .relay_drive);

   sdm_ctrl_model ctl (
      .mclk, .sweep_limit_pulse, .marker_preset_n, .marker_clear_n, .marker_next_value,
      .hramp_preset_n, .hramp_clear_n, .hramp_next_value, .range_short, .range_long);

   // 50 MHz clock
   initial begin
      mclk = 1'h0;
      forever #10 mclk = ~mclk;
   end

   task automatic wrap_up();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Settle point just after an edge
   task automatic at1();
      @(posedge mclk);
      #1;
   endtask

   task automatic cpulse(input logic st, input logic en);
      @(posedge mclk);
      ctrl.sweep_start <= st;
      ctrl.sweep_end   <= en;
      @(posedge mclk);
      ctrl.sweep_start <= 1'h0;
      ctrl.sweep_end   <= 1'h0;
      #1;
   endtask

   // Width of a high pulse in cycles; bounded so a stuck output cannot hang
   task automatic meas(input int sel, input int exp, input string nm);
      int n;
      n = 0;
      while ((sel == 0 ? hramp_reset : relay_drive[3]) === 1'h1 && n < 200) begin
         at1();
         n++;
      end
      if (n == 200) begin
         fails++;
         wrap_up();
      end
      chk(nm, exp, n);
   endtask

   // Hang guard, well past the longest sequence
   initial begin
      #1000000;
      fails++;
      wrap_up();
   end

   // Main sequence
   initial begin
      fails = 0;
      checks = 0;
      rstn = 1'h0;
      ctrl = '0;
      out_freq_hz = 32'hFA0;
      phase_det_reset = 1'h0;
      flag_clear = 1'h0;
      analog_ramp_reset_pos = 1'h0;
      analog_ramp_reset_neg = 1'h0;
      relay_request = 8'h00;
      repeat (3) @(posedge mclk);
      rstn <= 1'h1;
      at1();
      chk("blank", 1'h1, sweep_blank);
      chk("flag", 1'h0, function_integrity_bit);
      chk("relay", 8'h00, relay_drive);
      // Single sweep window; ramp reset fires at the sweep start
      @(posedge mclk) ctrl.single_mode <= 1'h1;
      cpulse(1'h1, 1'h0);
      chk("blank", 1'h0, sweep_blank);
      meas(0, 50, "ramp_rst");
      cpulse(1'h0, 1'h1);
      chk("blank", 1'h1, sweep_blank);
      repeat (10) at1();
      chk("blank", 1'h1, sweep_blank);
      chk("ramp_rst", 1'h0, hramp_reset);
      // Continuous sweep with marker traffic on the way up
      @(posedge mclk) ctrl.single_mode <= 1'h0;
      cpulse(1'h1, 1'h0);
      chk("blank", 1'h0, sweep_blank);
      ctl.strobe(1'h0, 1'h1, 1'h1, 1'h1);
      at1();
      chk("marker", 1'h1, marker_out);
      ctl.strobe(1'h1, 1'h0, 1'h1, 1'h1);
      at1();
      chk("marker", 1'h0, marker_out);
      ctl.strobe(1'h1, 1'h1, 1'h1, 1'h1);
      ctl.limit(1'h1, 1'h0);
      at1();
      chk("marker", 1'h1, marker_out);
      @(posedge mclk) ctrl.log_sweep <= 1'h1;
      at1();
      chk("marker", 1'h0, marker_out);
      @(posedge mclk) ctrl.log_sweep <= 1'h0;
      @(posedge mclk) ctrl.sweep_down <= 1'h1;
      at1();
      chk("blank", 1'h1, sweep_blank);
      chk("marker", 1'h0, marker_out);
      meas(0, 50, "ramp_rst");
      @(posedge mclk) ctrl.sweep_down <= 1'h0;
      at1();
      chk("blank", 1'h0, sweep_blank);
      chk("marker", 1'h1, marker_out);
      ctl.limit(1'h0, 1'h0);
      repeat (5) at1();
      chk("marker", 1'h0, marker_out);
      // Ramp element, range switches and preset hold-off
      ctl.rng(32'h1F4);
      ctl.strobe(1'h1, 1'h1, 1'h0, 1'h1);
      at1();
      chk("run", 1'h1, hramp_run);
      chk("sw_short", 1'h1, switch_short);
      chk("sw_long", 1'h0, switch_long);
      ctl.limit(1'h1, 1'h0);
      at1();
      chk("run", 1'h1, hramp_run);
      ctl.rng(32'h4E20);
      ctl.strobe(1'h1, 1'h1, 1'h1, 1'h1);
      at1();
      chk("run", 1'h1, hramp_run);
      chk("sw_long", 1'h1, switch_long);
      chk("sw_short", 1'h0, switch_short);
      ctl.limit(1'h0, 1'h0);
      at1();
      chk("run", 1'h0, hramp_run);
      chk("sw_long", 1'h0, switch_long);
      ctl.limit(1'h0, 1'h1);
      at1();
      chk("run", 1'h1, hramp_run);
      ctl.strobe(1'h1, 1'h1, 1'h1, 1'h0);
      at1();
      chk("run", 1'h0, hramp_run);
      ctl.strobe(1'h1, 1'h1, 1'h1, 1'h1);
      // Reset method and integrity flag
      @(posedge mclk) out_freq_hz <= 32'h63;
      repeat (2) at1();
      chk("digital", 1'h1, use_digital_reset);
      @(posedge mclk) phase_det_reset <= 1'h1;
      @(posedge mclk) phase_det_reset <= 1'h0;
      at1();
      chk("flag", 1'h1, function_integrity_bit);
      for (int i = 0; i < 2; i++) begin
         @(posedge mclk) flag_clear <= 1'h1;
         @(posedge mclk) flag_clear <= 1'h0;
         phase_det_reset <= 1'h1;
         analog_ramp_reset_pos <= (i == 0);
         analog_ramp_reset_neg <= (i == 1);
         @(posedge mclk) phase_det_reset <= 1'h0;
         analog_ramp_reset_pos <= 1'h0;
         analog_ramp_reset_neg <= 1'h0;
         repeat (2) at1();
         chk("flag", 1'h0, function_integrity_bit);
      end
      @(posedge mclk) out_freq_hz <= 32'h64;
      repeat (2) at1();
      chk("digital", 1'h0, use_digital_reset);
      // Latching relay drive turns itself off
      @(posedge mclk) relay_request <= 8'h08;
      @(posedge mclk) relay_request <= 8'h00;
      #1;
      chk("relay", 8'h08, relay_drive);
      meas(1, RCYC, "relay_on");
      chk("relay", 8'h00, relay_drive);
      wrap_up();
   end
endmodule
